// >>> logic/sfria_space.v
// Special register space decoder with three indirect access ports
`timescale 1ns/10ps
`include "sfria_defines.vh"
// What this block does
// - Unused locations read zero, ignore writes
// - Read-only locations read back, ignore writes
// - Reserved locations keep value on write
// - Indirect port access goes to pointer target
// - Port zero uses one pointer, sector 0
// - Port one uses low byte plus sector
// - Port two uses low byte plus sector
// - Port as storage reads zero, ignores write
// - Registers low half, RAM upper half
// - Sector byte picks sector, low picks address
// - Registers decoded in sectors 0 and 1
module sfria_space (
  clk_sys,
  rst_n,
  acc_sector,
  acc_addr,
  acc_rd,
  acc_wr,
  acc_wdata,
  acc_rdata,
  per_sel,
  per_sector,
  per_addr,
  per_wr,
  per_wdata,
  per_rdata,
  per_used,
  per_ro,
  pointer_zero,
  pointer_one_low,
  pointer_one_sector,
  pointer_two_low,
  pointer_two_sector
);
  input wire clk_sys;
  input wire rst_n;
  input wire [3:0] acc_sector;
  input wire [7:0] acc_addr;
  input wire acc_rd;
  input wire acc_wr;
  input wire [7:0] acc_wdata;
  output wire [7:0] acc_rdata;
  output wire per_sel;
  output wire [3:0] per_sector;
  output wire [7:0] per_addr;
  output wire per_wr;
  output wire [7:0] per_wdata;
  input wire [7:0] per_rdata;
  input wire per_used;
  input wire per_ro;
  output wire [7:0] pointer_zero;
  output wire [7:0] pointer_one_low;
  output wire [7:0] pointer_one_sector;
  output wire [7:0] pointer_two_low;
  output wire [7:0] pointer_two_sector;

  reg [7:0] ptr0_q;
  reg [7:0] ptr1_low_q;
  reg [7:0] ptr1_sec_q;
  reg [7:0] ptr2_low_q;
  reg [7:0] ptr2_sec_q;
  reg [7:0] ptr0_d;
  reg [7:0] ptr1_low_d;
  reg [7:0] ptr1_sec_d;
  reg [7:0] ptr2_low_d;
  reg [7:0] ptr2_sec_d;
  reg [3:0] eff_sector;
  reg [7:0] eff_addr;
  reg [1:0] rd_src;
  wire dir_port;
  wire eff_port;
  wire eff_ptr;
  wire eff_used;
  wire eff_ro;
  wire eff_gp;
  wire any_acc;
  wire nested_port;
  wire sfr_hit;
  wire per_ok;
  wire wr_block;
  wire ptr_wr;
  wire wr_ptr0;
  wire wr_ptr1_low;
  wire wr_ptr1_sec;
  wire wr_ptr2_low;
  wire wr_ptr2_sec;
  wire ram_we;
  wire [10:0] ram_addr;
  wire [7:0] ram_rdata;
  reg [7:0] ptr_rdata;
  reg [7:0] rdata_mux;

  // Where a read is answered from
  localparam [1:0] SRC_ZERO = 2'h0;
  localparam [1:0] SRC_RAM = 2'h1;
  localparam [1:0] SRC_PTR = 2'h2;
  localparam [1:0] SRC_PER = 2'h3;

  // Sector field is the low nibble of the sector pointer byte
  function [3:0] sec_of;
    input [7:0] sec_byte;
    begin
      sec_of = sec_byte[`SFRIA_SEC_W-1:0];
    end
  endfunction

  // RAM row: sector on top, low seven address bits below
  function [10:0] ram_index;
    input [3:0] sector;
    input [7:0] addr;
    begin
      ram_index = {sector, addr[6:0]};
    end
  endfunction

  sfria_sfr_decode u_dir_dec (
    .sector(acc_sector),
    .addr(acc_addr),
    .is_port(dir_port),
    .is_ptr(),
    .is_used(),
    .is_ro()
  );

  // Port addresses are replaced by the paired pointer target
  // Only one hop: a pointer naming a port leaves eff_addr on that port
  always @* begin
    eff_sector = acc_sector;
    eff_addr = acc_addr;
    if (dir_port) begin
      case (acc_addr)
        `SFRIA_ADDR_PORT0: begin
          eff_sector = `SFRIA_SEC_ZERO;
          eff_addr = ptr0_q;
        end
        `SFRIA_ADDR_PORT1: begin
          eff_sector = sec_of(ptr1_sec_q);
          eff_addr = ptr1_low_q;
        end
        `SFRIA_ADDR_PORT2: begin
          eff_sector = sec_of(ptr2_sec_q);
          eff_addr = ptr2_low_q;
        end
        default: begin
          eff_addr = acc_addr;
        end
      endcase
    end
  end

  sfria_sfr_decode u_eff_dec (
    .sector(eff_sector),
    .addr(eff_addr),
    .is_port(eff_port),
    .is_ptr(eff_ptr),
    .is_used(eff_used),
    .is_ro(eff_ro)
  );

  // Upper half of each sector is general RAM
  assign eff_gp = eff_addr[`SFRIA_GP_BIT];
  assign any_acc = acc_rd || acc_wr;
  // A port reached through a pointer holds nothing
  assign nested_port = dir_port && eff_port;
  assign sfr_hit = !eff_gp && !eff_port && !eff_ptr && eff_used;
  assign ram_we = acc_wr && eff_gp;
  assign ram_addr = ram_index(eff_sector, eff_addr);

  sfria_gp_ram u_ram (
    .clk_sys(clk_sys),
    .we(ram_we),
    .addr(ram_addr),
    .wdata(acc_wdata),
    .rdata(ram_rdata)
  );

  // Peripheral side sees only non-pointer, non-port register locations
  assign per_sel = any_acc && sfr_hit;
  assign per_sector = eff_sector;
  assign per_addr = eff_addr;
  assign per_ok = eff_used && per_used;
  // Protection class comes from the peripheral, the local decode adds none yet
  assign wr_block = per_ro || eff_ro;
  // Read-only, reserved and unused locations never see a write
  assign per_wr = acc_wr && per_sel && per_ok && !wr_block;
  assign per_wdata = acc_wdata;

  // Pointer locations are plain storage in every sector
  assign ptr_wr = acc_wr && !eff_gp && eff_ptr;
  assign wr_ptr0 = ptr_wr && (eff_addr == `SFRIA_ADDR_PTR0);
  assign wr_ptr1_low = ptr_wr && (eff_addr == `SFRIA_ADDR_PTR1_LOW);
  assign wr_ptr1_sec = ptr_wr && (eff_addr == `SFRIA_ADDR_PTR1_SEC);
  assign wr_ptr2_low = ptr_wr && (eff_addr == `SFRIA_ADDR_PTR2_LOW);
  assign wr_ptr2_sec = ptr_wr && (eff_addr == `SFRIA_ADDR_PTR2_SEC);

  // Whole byte is kept; only the low nibble of a sector byte steers
  always @* begin
    ptr0_d = ptr0_q;
    ptr1_low_d = ptr1_low_q;
    ptr1_sec_d = ptr1_sec_q;
    ptr2_low_d = ptr2_low_q;
    ptr2_sec_d = ptr2_sec_q;
    if (wr_ptr0) begin
      ptr0_d = acc_wdata;
    end
    if (wr_ptr1_low) begin
      ptr1_low_d = acc_wdata;
    end
    if (wr_ptr1_sec) begin
      ptr1_sec_d = acc_wdata;
    end
    if (wr_ptr2_low) begin
      ptr2_low_d = acc_wdata;
    end
    if (wr_ptr2_sec) begin
      ptr2_sec_d = acc_wdata;
    end
  end

  // Pointer writes land at this edge, so the next access uses them
  always @(posedge clk_sys) begin
    if (!rst_n) begin
      ptr0_q <= `SFRIA_PTR_RESET;
      ptr1_low_q <= `SFRIA_PTR_RESET;
      ptr1_sec_q <= `SFRIA_PTR_RESET;
      ptr2_low_q <= `SFRIA_PTR_RESET;
      ptr2_sec_q <= `SFRIA_PTR_RESET;
    end else begin
      ptr0_q <= ptr0_d;
      ptr1_low_q <= ptr1_low_d;
      ptr1_sec_q <= ptr1_sec_d;
      ptr2_low_q <= ptr2_low_d;
      ptr2_sec_q <= ptr2_sec_d;
    end
  end

  // Pointer read back
  always @* begin
    case (eff_addr)
      `SFRIA_ADDR_PTR0: begin
        ptr_rdata = ptr0_q;
      end
      `SFRIA_ADDR_PTR1_LOW: begin
        ptr_rdata = ptr1_low_q;
      end
      `SFRIA_ADDR_PTR1_SEC: begin
        ptr_rdata = ptr1_sec_q;
      end
      `SFRIA_ADDR_PTR2_LOW: begin
        ptr_rdata = ptr2_low_q;
      end
      `SFRIA_ADDR_PTR2_SEC: begin
        ptr_rdata = ptr2_sec_q;
      end
      default: begin
        ptr_rdata = `SFRIA_ZERO_BYTE;
      end
    endcase
  end

  // Pick the answer source; anything without storage reads as zero
  always @* begin
    rd_src = SRC_ZERO;
    if (!acc_rd) begin
      rd_src = SRC_ZERO;
    end else if (eff_gp) begin
      rd_src = SRC_RAM;
    end else if (nested_port) begin
      rd_src = SRC_ZERO;
    end else if (eff_ptr) begin
      rd_src = SRC_PTR;
    end else if (per_ok) begin
      rd_src = SRC_PER;
    end else begin
      rd_src = SRC_ZERO;
    end
  end

  // Read data selection
  always @* begin
    case (rd_src)
      SRC_RAM: begin
        rdata_mux = ram_rdata;
      end
      SRC_PTR: begin
        rdata_mux = ptr_rdata;
      end
      SRC_PER: begin
        rdata_mux = per_rdata;
      end
      default: begin
        rdata_mux = `SFRIA_ZERO_BYTE;
      end
    endcase
  end

  // Combinational read keeps the core's one-cycle data path
  assign acc_rdata = rdata_mux;

  assign pointer_zero = ptr0_q;
  assign pointer_one_low = ptr1_low_q;
  assign pointer_one_sector = ptr1_sec_q;
  assign pointer_two_low = ptr2_low_q;
  assign pointer_two_sector = ptr2_sec_q;
endmodule

// >>> include/sfria_defines.vh
// Address map, pointer layout and reset values for the special register space decoder
`ifndef SFRIA_DEFINES_VH
`define SFRIA_DEFINES_VH
`define SFRIA_ADDR_PORT0 8'h00
`define SFRIA_ADDR_PTR0 8'h01
`define SFRIA_ADDR_PORT1 8'h02
`define SFRIA_ADDR_PTR1_LOW 8'h03
`define SFRIA_ADDR_PTR1_SEC 8'h04
`define SFRIA_ADDR_PORT2 8'h0c
`define SFRIA_ADDR_PTR2_LOW 8'h0d
`define SFRIA_ADDR_PTR2_SEC 8'h0e
`define SFRIA_GP_BIT 7
`define SFRIA_SEC_W 4
`define SFRIA_SEC_NUM 16
`define SFRIA_SEC_ZERO 4'h0
`define SFRIA_SEC_ONE 4'h1
`define SFRIA_PTR_RESET 8'h00
`define SFRIA_ZERO_BYTE 8'h00
`define SFRIA_GP_DEPTH 2048
`endif

// >>> logic/sfria_gp_ram.v
// General purpose RAM, upper half of every sector
`timescale 1ns/10ps
`include "sfria_defines.vh"
module sfria_gp_ram (
  clk_sys,
  we,
  addr,
  wdata,
  rdata
);
  input wire clk_sys;
  input wire we;
  input wire [10:0] addr;
  input wire [7:0] wdata;
  output wire [7:0] rdata;
  reg [7:0] mem [0:`SFRIA_GP_DEPTH-1];
  // Asynchronous read keeps the core's single-cycle read path
  assign rdata = mem[addr];
  always @(posedge clk_sys) begin
    if (we) begin
      mem[addr] <= wdata;
    end
  end
endmodule

// >>> logic/sfria_sfr_decode.v
// Classifies a special register address in a sector
`timescale 1ns/10ps
`include "sfria_defines.vh"
module sfria_sfr_decode (
  sector,
  addr,
  is_port,
  is_ptr,
  is_used,
  is_ro
);
  input wire [3:0] sector;
  input wire [7:0] addr;
  output wire is_port;
  output wire is_ptr;
  output wire is_used;
  output wire is_ro;
  // Pointer and port locations decode alike in every sector
  assign is_port = (addr == `SFRIA_ADDR_PORT0) || (addr == `SFRIA_ADDR_PORT1) ||
    (addr == `SFRIA_ADDR_PORT2);
  assign is_ptr = (addr == `SFRIA_ADDR_PTR0) || (addr == `SFRIA_ADDR_PTR1_LOW) ||
    (addr == `SFRIA_ADDR_PTR1_SEC) || (addr == `SFRIA_ADDR_PTR2_LOW) ||
    (addr == `SFRIA_ADDR_PTR2_SEC);
  // Peripheral locations live in sectors 0 and 1 only
  assign is_used = (sector == `SFRIA_SEC_ZERO) || (sector == `SFRIA_SEC_ONE);
  // Peripheral registers sit outside this block; none is read-only here
  assign is_ro = 1'b0;
endmodule

// >>> verification/sfria_per_model.sv
// Peripheral register model behind the decoder
`timescale 1ns/10ps
module sfria_per_model (
  input wire clk_sys,
  input wire per_sel,
  input wire [3:0] per_sector,
  input wire [7:0] per_addr,
  input wire per_wr,
  input wire [7:0] per_wdata,
  output wire [7:0] per_rdata,
  output wire per_used,
  output wire per_ro
);
  reg [7:0] reg_q = 8'hc3;
  reg [7:0] ro_q = 8'h5a;
  wire hit_rw = per_sel && per_sector == 4'h1 && per_addr == 8'h06;
  wire hit_ro = per_sel && per_sector == 4'h0 && per_addr == 8'h0a;
  assign per_used = hit_rw || hit_ro;
  assign per_ro = hit_ro;
  // Junk when unused, so a zero must come from the decoder
  assign per_rdata = hit_ro ? ro_q : (hit_rw ? reg_q : ~reg_q);
  always @(posedge clk_sys) begin
    if (per_wr && hit_rw) begin
      reg_q <= per_wdata;
    end
    // A write leaking past the guard shows on the next read
    if (per_wr && hit_ro) begin
      ro_q <= per_wdata;
    end
  end
endmodule

// >>> verification/sfria_space_assertions.sv
// Port checker for the register space decoder
`timescale 1ns/10ps
module sfria_space_chk (
  input wire clk_sys,
  input wire rst_n,
  input wire [7:0] acc_addr,
  input wire acc_rd,
  input wire acc_wr,
  input wire [7:0] acc_wdata,
  input wire [7:0] acc_rdata,
  input wire per_sel,
  input wire [3:0] per_sector,
  input wire [7:0] per_addr,
  input wire per_wr,
  input wire per_used,
  input wire per_ro,
  input wire [7:0] pointer_zero,
  input wire [7:0] pointer_one_low,
  input wire [7:0] pointer_one_sector,
  input wire [7:0] pointer_two_low,
  input wire [7:0] pointer_two_sector
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  wire acc = acc_rd || acc_wr;
  sequence s_ptr0_wr;
    acc_wr && acc_addr == 8'h01;
  endsequence
  chk_ptr_update:
    assert property (s_ptr0_wr |=> pointer_zero == $past(acc_wdata)) else $error("ptr0 stale");
  chk_port0_target:
    assert property (acc && acc_addr == 8'h00 |-> per_sector == 4'h0 && per_addr == pointer_zero)
      else $error("port0 target");
  chk_port1_target:
    assert property (acc && acc_addr == 8'h02 |-> per_sector == pointer_one_sector[3:0]
      && per_addr == pointer_one_low) else $error("port1 target");
  chk_port2_target:
    assert property (acc && acc_addr == 8'h0c |-> per_sector == pointer_two_sector[3:0]
      && per_addr == pointer_two_low) else $error("port2 target");
  chk_write_guard:
    assert property (per_wr |-> acc_wr && per_used && !per_ro) else $error("bad write");
  chk_unused_zero:
    assert property (acc_rd && per_sel && !per_used |-> acc_rdata == 8'h00) else $error("unused");
  chk_port_storage:
    assert property (acc_rd && acc_addr == 8'h00 && (pointer_zero == 8'h00
      || pointer_zero == 8'h02 || pointer_zero == 8'h0c) |-> acc_rdata == 8'h00) else $error("port");
  chk_sfr_half:
    assert property (per_sel |-> !per_addr[7] && per_sector < 4'h2) else $error("sfr decode");
endmodule
bind sfria_space sfria_space_chk sfria_space_chk_inst (.clk_sys(clk_sys), .rst_n(rst_n),
  .acc_addr(acc_addr), .acc_rd(acc_rd), .acc_wr(acc_wr), .acc_wdata(acc_wdata),
  .acc_rdata(acc_rdata), .per_sel(per_sel), .per_sector(per_sector), .per_addr(per_addr),
  .per_wr(per_wr), .per_used(per_used), .per_ro(per_ro), .pointer_zero(pointer_zero),
  .pointer_one_low(pointer_one_low), .pointer_one_sector(pointer_one_sector),
  .pointer_two_low(pointer_two_low), .pointer_two_sector(pointer_two_sector));

// >>> verification/sfria_space_bench.sv
// Directed bench for the register space decoder
`timescale 1ns/10ps
module sfria_space_bench;
  reg clk_sys = 1'b0;
  reg rst_n = 1'b0;
  reg [3:0] acc_sector = 4'h0;
  reg [7:0] acc_addr = 8'h00;
  reg acc_rd = 1'b0;
  reg acc_wr = 1'b0;
  reg [7:0] acc_wdata = 8'h00;
  wire [7:0] acc_rdata, per_addr, per_wdata, per_rdata, p0, p1l, p1s, p2l, p2s;
  wire [3:0] per_sector;
  wire per_sel, per_wr, per_used, per_ro;
  integer n_mismatch = 0;
  integer n_tests = 0;
  sfria_space sfria_space_inst (.clk_sys(clk_sys), .rst_n(rst_n), .acc_sector(acc_sector),
    .acc_addr(acc_addr), .acc_rd(acc_rd), .acc_wr(acc_wr), .acc_wdata(acc_wdata),
    .acc_rdata(acc_rdata), .per_sel(per_sel), .per_sector(per_sector), .per_addr(per_addr),
    .per_wr(per_wr), .per_wdata(per_wdata), .per_rdata(per_rdata), .per_used(per_used),
    .per_ro(per_ro), .pointer_zero(p0), .pointer_one_low(p1l), .pointer_one_sector(p1s),
    .pointer_two_low(p2l), .pointer_two_sector(p2s));
  sfria_per_model sfria_per_model_inst (.clk_sys(clk_sys), .per_sel(per_sel),
    .per_sector(per_sector), .per_addr(per_addr), .per_wr(per_wr), .per_wdata(per_wdata),
    .per_rdata(per_rdata), .per_used(per_used), .per_ro(per_ro));
  initial begin
    forever #50 clk_sys = ~clk_sys;
  end
  task chk(input [7:0] exp, input [7:0] got, input string nm);
    n_tests = n_tests + 1;
    if (got !== exp) begin
      n_mismatch = n_mismatch + 1;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task wr(input [3:0] s, input [7:0] a, input [7:0] d);
    @(negedge clk_sys);
    acc_sector = s;
    acc_addr = a;
    acc_wdata = d;
    acc_wr = 1'b1;
    @(negedge clk_sys);
    acc_wr = 1'b0;
  endtask
  // Combinational answer, sampled a little after the inputs settle
  task rd(input [3:0] s, input [7:0] a, input [7:0] exp, input string nm);
    @(negedge clk_sys);
    acc_sector = s;
    acc_addr = a;
    acc_rd = 1'b1;
    #5 chk(exp, acc_rdata, nm);
    @(negedge clk_sys);
    acc_rd = 1'b0;
  endtask
  task tally_and_finish;
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  initial begin
    repeat (2) @(negedge clk_sys);
    rst_n = 1'b1;
    rd(4'h0, 8'h01, 8'h00, "ptr0 reset");
    wr(4'h0, 8'h01, 8'h85);
    chk(8'h85, p0, "ptr0");
    wr(4'h3, 8'h00, 8'h3c);
    rd(4'h0, 8'h85, 8'h3c, "port0 target");
    rd(4'h7, 8'h00, 8'h3c, "port0 read");
    wr(4'h0, 8'h04, 8'h05);
    wr(4'h0, 8'h03, 8'h90);
    chk(8'h05, p1s, "ptr1 sector");
    chk(8'h90, p1l, "ptr1 low");
    wr(4'h0, 8'h02, 8'h11);
    rd(4'h5, 8'h90, 8'h11, "port1");
    wr(4'h0, 8'h0e, 8'h1f);
    wr(4'h0, 8'h0d, 8'hff);
    wr(4'h2, 8'h0c, 8'h22);
    rd(4'hf, 8'hff, 8'h22, "port2");
    chk(8'h1f, p2s, "ptr2 sector");
    chk(8'hff, p2l, "ptr2 low");
    wr(4'h0, 8'h01, 8'h0c);
    wr(4'h0, 8'h00, 8'h77);
    rd(4'h0, 8'h00, 8'h00, "port as target");
    rd(4'h0, 8'h0c, 8'h22, "port2 kept");
    wr(4'h3, 8'h10, 8'h44);
    rd(4'h3, 8'h10, 8'h00, "unused sector3");
    rd(4'h0, 8'h0b, 8'h00, "unused sector0");
    wr(4'h0, 8'h0a, 8'h00);
    rd(4'h0, 8'h0a, 8'h5a, "read only");
    wr(4'h1, 8'h06, 8'h66);
    rd(4'h1, 8'h06, 8'h66, "sector1 reg");
    rd(4'h0, 8'h06, 8'h00, "sector0 same addr");
    wr(4'h1, 8'h80, 8'h99);
    rd(4'h1, 8'h80, 8'h99, "ram");
    wr(4'h0, 8'h04, 8'h01);
    wr(4'h0, 8'h03, 8'h06);
    rd(4'h0, 8'h02, 8'h66, "port1 to reg");
    tally_and_finish;
  end
endmodule
